// ===== hdl/lss_top.sv
/*
  led start-up sequencer top: enable and lockout gating, sink pin detection,
  soft start and regulation, and reaction to the frequency-set/sync pin.
  assumes comparator flags synchronous to clk, apb master on clk.
*/
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "lss_regs.svh"
module lss_top (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           enable,
  input  wire logic           supplyAboveRise,
  input  wire lss_pkg::lss_ch_t sinkAboveDetect,
  input  wire lss_pkg::lss_ch_t sinkBelowShort,
  input  wire lss_pkg::lss_ch_t sinkAboveLed,
  input  wire logic           headroomOk,
  input  wire logic           freqSetSyncPin,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output      logic [31:0]    prdata,
  output      logic           pready,
  output      logic           pslverr,
  output      logic           switchEn,
  output      lss_pkg::lss_ch_t sinkEn,
  output      logic           softstartSinkGain,
  output      logic           softstartSenseLimit,
  output      logic           useExtClock
);
  import lss_pkg::*;

  lss_state_e  state;
  lss_state_e  next_state;
  logic        rstSync1;
  logic        rstSync2;
  logic [10:0] detCnt;
  lss_ch_t     unusedCh;
  lss_ch_t     shortCh;
  lss_ch_t     next_unusedCh;
  logic [31:0] ctrl;
  logic [31:0] status;
  logic [31:0] chan;
  logic        runOn;
  logic        skipDetect;
  logic        powered;
  lss_if       sw ();

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  lss_sync_watch u_watch (
    .clk            (clk),
    .rstn           (rstSync2),
    .freqSetSyncPin (freqSetSyncPin),
    .wo             (sw.src)
  );

  lss_apb_regs u_regs (
    .clk     (clk),
    .rstn    (rstSync2),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl    (ctrl),
    .status  (status),
    .chan    (chan)
  );

  assign runOn      = ctrl[`LSS_CTRL_RUN_BIT];
  assign skipDetect = ctrl[`LSS_CTRL_SKIP_BIT];
  assign powered    = enable && supplyAboveRise && runOn;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      LSS_OFF: begin
        if (powered) begin
          next_state = skipDetect ? LSS_SOFTSTART : LSS_WAIT_RISE;
        end
      end
      LSS_WAIT_RISE: begin
        if (|sinkBelowShort) begin
          next_state = LSS_SHORT_HOLD;
        end else if (|sinkAboveDetect) begin
          next_state = LSS_DETECT;
        end
      end
      LSS_DETECT: begin
        if (detCnt == 11'(`LSS_DETECT_CYC - 1)) begin
          next_state = (|(sinkBelowShort & ~unusedCh)) ? LSS_SHORT_HOLD : LSS_SOFTSTART;
        end
      end
      LSS_SHORT_HOLD: begin
        if (!(|(sinkBelowShort & ~unusedCh)) && |(shortCh & sinkAboveLed)) begin
          next_state = LSS_DETECT;
        end else if (!(|(sinkBelowShort & ~unusedCh)) && shortCh == 4'h0) begin
          next_state = LSS_DETECT;
        end
      end
      LSS_SOFTSTART: begin
        if (headroomOk) begin
          next_state = LSS_REGULATE;
        end
      end
      LSS_REGULATE: begin
        next_state = LSS_REGULATE;
      end
      LSS_FSET_FAULT: begin
        if (sw.fsetLongRel) begin
          next_state = LSS_SOFTSTART;
        end else if (!sw.fsetShort && !sw.extSync) begin
          next_state = LSS_WAIT_RISE;
        end
      end
      default: next_state = LSS_OFF;
    endcase
    if (sw.fsetShort && state != LSS_OFF) begin
      next_state = LSS_FSET_FAULT;
    end
    if (!powered) begin
      next_state = LSS_OFF;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      state <= LSS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // detection timer
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      detCnt <= 11'h000;
    end else if (state == LSS_DETECT) begin
      detCnt <= detCnt + 11'h001;
    end else begin
      detCnt <= 11'h000;
    end
  end

  // classification that takes effect at the end of detection; the sink
  // enables use it too, so an unused pin is never switched on for a cycle once detection has run; with detection skipped all four sinks come on
  always_comb begin
    if (state == LSS_OFF) begin
      next_unusedCh = 4'h0;
    end else if (state == LSS_DETECT && detCnt == 11'(`LSS_DETECT_CYC - 1)) begin
      next_unusedCh = ~sinkBelowShort & ~sinkAboveLed;
    end else begin
      next_unusedCh = unusedCh;
    end
  end

  // channel classification during detection
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      unusedCh <= 4'h0;
      shortCh  <= 4'h0;
    end else if (state == LSS_OFF) begin
      unusedCh <= 4'h0;
      shortCh  <= 4'h0;
    end else if (state == LSS_DETECT && detCnt == 11'(`LSS_DETECT_CYC - 1)) begin
      unusedCh <= next_unusedCh;
      shortCh  <= sinkBelowShort;
    end else if (state == LSS_SHORT_HOLD) begin
      shortCh <= shortCh & ~sinkAboveLed;
    end
  end

  // drive outputs from flops
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      switchEn            <= 1'b0;
      sinkEn              <= 4'h0;
      softstartSinkGain   <= 1'b0;
      softstartSenseLimit <= 1'b0;
      useExtClock         <= 1'b0;
    end else begin
      useExtClock <= sw.extSync;
      softstartSinkGain   <= (next_state == LSS_SOFTSTART);
      softstartSenseLimit <= (next_state == LSS_SOFTSTART);
      if ((next_state == LSS_SOFTSTART || next_state == LSS_REGULATE) && !sw.pause) begin
        switchEn <= 1'b1;
        sinkEn   <= ~next_unusedCh;
      end else begin
        switchEn <= 1'b0;
        sinkEn   <= (next_state == LSS_SOFTSTART || next_state == LSS_REGULATE)
                    ? ~next_unusedCh : 4'h0;
      end
    end
  end

  // status words
  assign status = {24'h00_0000, softstartSenseLimit, softstartSinkGain, sw.fsetShort,
                   sw.extSync, 1'b0, state};
  assign chan   = {24'h00_0000, shortCh, unusedCh};
endmodule

// ===== hdl/lss_regs.svh
/*
  constants for the led start-up sequencer: register offsets, field positions,
  reset values and timing figures.
  assumes it is included by bare name from every design file that needs it.
*/
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

// register byte offsets and the control reset value
`define LSS_CTRL_OFF       12'h000
`define LSS_STATUS_OFF     12'h004
`define LSS_CHAN_OFF       12'h008
`define LSS_CTRL_RST       32'h0000_0001
// control fields
`define LSS_CTRL_RUN_BIT   0
`define LSS_CTRL_SKIP_BIT  1
// status and channel word fields
`define LSS_ST_STATE_LSB   0
`define LSS_ST_SYNC_BIT    4
`define LSS_ST_FSHORT_BIT  5
`define LSS_ST_SSGAIN_BIT  6
`define LSS_ST_SSLIM_BIT   7
`define LSS_CH_UNUSED_LSB  0
`define LSS_CH_SHORT_LSB   4
// timing
`define LSS_CLK_MHZ        100
`define LSS_DETECT_CYC     1536
`define LSS_FSHORT_NS      4000
`define LSS_FREL_NS        7000
`define LSS_PAUSE_NS       5000
`define LSS_SYNC_LOSS_NS   4000
`define LSS_NS_TO_CYC(ns)  (((ns) * `LSS_CLK_MHZ) / 1000)
// figures carried for the analog side
`define LSS_SS_GAIN_AA     88
`define LSS_SS_LIM_MV      39
`define LSS_NCH            4

`endif

// ===== hdl/lss_pkg.sv
/*
  types shared by the led start-up sequencer files.
  assumes nothing beyond a systemverilog compiler.
*/
package lss_pkg;
  typedef enum logic [2:0] {
    LSS_OFF,
    LSS_WAIT_RISE,
    LSS_DETECT,
    LSS_SHORT_HOLD,
    LSS_SOFTSTART,
    LSS_REGULATE,
    LSS_FSET_FAULT
  } lss_state_e;
  typedef logic [3:0] lss_ch_t;
endpackage

// ===== hdl/lss_if.sv
/*
  interface carrying the sync pin supervisor results to the sequencer.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
interface lss_if;
  logic fsetShort;   // pin low past short-detect time
  logic fsetLongRel; // pulse: released after the long short
  logic extSync;     // external clock in use
  logic pause;       // changeover pause, switching held
  modport src (output fsetShort, output fsetLongRel, output extSync, output pause);
  modport dst (input fsetShort, input fsetLongRel, input extSync, input pause);
endinterface

// ===== hdl/lss_sync_watch.sv
/*
  watches the frequency-set/sync pin: short to ground, long release, and
  presence of an external clock with a changeover pause.
  assumes the pin level is synchronous to clk and the clock is an internal
  time base independent of switching.
*/
`timescale 1ns/1ns
`include "lss_regs.svh"
module lss_sync_watch (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic freqSetSyncPin,
  lss_if.src        wo
);
  import lss_pkg::*;
  localparam int SHORT_CYC = `LSS_NS_TO_CYC(`LSS_FSHORT_NS);
  localparam int REL_CYC   = `LSS_NS_TO_CYC(`LSS_FREL_NS);
  localparam int PAUSE_CYC = `LSS_NS_TO_CYC(`LSS_PAUSE_NS);
  localparam int LOSS_CYC  = `LSS_NS_TO_CYC(`LSS_SYNC_LOSS_NS);

  logic [9:0] lowCnt;
  logic [9:0] highCnt;
  logic [9:0] pauseCnt;
  logic       pinDly;
  logic       longShort;

  // low-time counter on the internal time base
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= 10'h000;
    end else if (freqSetSyncPin) begin
      lowCnt <= 10'h000;
    end else if (lowCnt != 10'h3FF) begin
      lowCnt <= lowCnt + 10'h001;
    end
  end

  // high-time counter, detects loss of the external clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highCnt <= 10'h000;
    end else if (!freqSetSyncPin) begin
      highCnt <= 10'h000;
    end else if (highCnt != 10'h3FF) begin
      highCnt <= highCnt + 10'h001;
    end
  end

  // short flag and release classification
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinDly      <= 1'b1;
      longShort   <= 1'b0;
      wo.fsetLongRel <= 1'b0;
    end else begin
      pinDly <= freqSetSyncPin;
      wo.fsetLongRel <= freqSetSyncPin && !pinDly && longShort;
      if (freqSetSyncPin) begin
        longShort <= 1'b0;
      end else if (lowCnt >= 10'(REL_CYC)) begin
        longShort <= 1'b1;
      end
    end
  end

  // pin short beyond the short-detect time
  assign wo.fsetShort = (lowCnt >= 10'(SHORT_CYC));

  // external clock seen as edges; lost once a level stands too long
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wo.extSync <= 1'b0;
      pauseCnt   <= 10'h000;
    end else begin
      if (!wo.extSync && !freqSetSyncPin && pinDly) begin
        wo.extSync <= 1'b1;
        pauseCnt   <= 10'(PAUSE_CYC);
      end else if (wo.extSync && (highCnt >= 10'(LOSS_CYC) || lowCnt >= 10'(LOSS_CYC))) begin
        wo.extSync <= 1'b0;
        pauseCnt   <= 10'(PAUSE_CYC);
      end else if (pauseCnt != 10'h000) begin
        pauseCnt <= pauseCnt - 10'h001;
      end
    end
  end

  assign wo.pause = (pauseCnt != 10'h000);
endmodule

// ===== hdl/lss_apb_regs.sv
/*
  apb slave holding the sequencer's control word and showing its status.
  assumes a standard apb master; zero wait states; unmapped reads give zero
  and raise pslverr.
*/
`timescale 1ns/1ns
`include "lss_regs.svh"
module lss_apb_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic [31:0] ctrl,
  input  wire logic [31:0] status,
  input  wire logic [31:0] chan
);
  function automatic logic mapped(input logic [11:0] a);
    return a == `LSS_CTRL_OFF || a == `LSS_STATUS_OFF || a == `LSS_CHAN_OFF;
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // control write on the access edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `LSS_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `LSS_CTRL_OFF) begin
      ctrl <= pwdata;
    end
  end

  // read data captured in the setup cycle, so it stands through the access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `LSS_CTRL_OFF:   prdata <= ctrl;
        `LSS_STATUS_OFF: prdata <= status;
        `LSS_CHAN_OFF:   prdata <= chan;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== test/lss_asserts.sv
/*
  port checks for the led start-up sequencer top.
  assumes one clock, active-low rstn, flags synchronous to clk.
*/
`timescale 1ns/1ns
module lss_asserts (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             enable,
  input wire logic             supplyAboveRise,
  input wire lss_pkg::lss_ch_t sinkBelowShort,
  input wire lss_pkg::lss_ch_t sinkAboveLed,
  input wire logic             headroomOk,
  input wire logic             freqSetSyncPin,
  input wire logic             switchEn,
  input wire lss_pkg::lss_ch_t sinkEn,
  input wire logic             softstartSinkGain,
  input wire logic             softstartSenseLimit,
  input wire logic             useExtClock
);
  import lss_pkg::*;
  logic [10:0] onCnt;  // cycles powered
  logic [9:0]  lowCnt; // cycles sync pin low
  logic [9:0]  stCnt;  // cycles sync pin steady
  logic        pinQ;   // sync pin one cycle back

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // powered time, cleared by enable or supply loss
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      onCnt <= '0;
    else if (!(enable && supplyAboveRise))
      onCnt <= '0;
    else if (onCnt != '1)
      onCnt <= onCnt + 11'd1;
  end

  // low time and steady time of the sync pin, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinQ <= 1'b1;
      lowCnt <= '0;
      stCnt <= '0;
    end else begin
      pinQ <= freqSetSyncPin;
      if (freqSetSyncPin)
        lowCnt <= '0;
      else if (lowCnt != '1)
        lowCnt <= lowCnt + 10'd1;
      if (freqSetSyncPin != pinQ)
        stCnt <= '0;
      else if (stCnt != '1)
        stCnt <= stCnt + 10'd1;
    end
  end

  power_gate_a: assert property ($rose(switchEn) |-> onCnt > 11'd2)
    else $error("switching began while not powered");
  off_when_low_a: assert property (!enable |-> ##[1:3] (!switchEn && sinkEn == 4'h0))
    else $error("outputs stayed on after enable fell");
  detect_first_a: assert property ($rose(|sinkEn) |-> onCnt > 11'd1536)
    else $error("sinks enabled before detection ended");
  unused_off_a: assert property ($rose(|sinkEn) |-> (sinkEn & ~sinkAboveLed) == 4'h0)
    else $error("unused sink enabled");
  short_hold_a: assert property (|sinkBelowShort |-> ##1 !softstartSinkGain)
    else $error("soft start with a shorted sink");
  sense_limit_a: assert property (softstartSinkGain == softstartSenseLimit)
    else $error("sense limit differs from gain phase");
  full_current_a: assert property (headroomOk && softstartSinkGain |->
    ##[1:3] (!softstartSenseLimit && !softstartSinkGain && sinkEn != 4'h0))
    else $error("no move to full current");
  fset_short_a: assert property (lowCnt > 10'd404 |-> !switchEn && sinkEn == 4'h0)
    else $error("running with sync pin shorted");
  fset_skip_a: assert property ($rose(freqSetSyncPin) && $past(lowCnt) > 10'd704
    && onCnt > 11'd2 |-> ##[1:3] softstartSinkGain)
    else $error("no direct soft start after long short");
  sync_loss_a: assert property (stCnt > 10'd404 |-> !useExtClock)
    else $error("external clock kept without edges");
  changeover_a: assert property ($changed(useExtClock) |-> ##[0:2] !switchEn [*8])
    else $error("switching during changeover");
endmodule

bind lss_top lss_asserts u_chk (.clk, .rstn, .enable, .supplyAboveRise, .sinkBelowShort,
  .sinkAboveLed, .headroomOk, .freqSetSyncPin, .switchEn, .sinkEn, .softstartSinkGain,
  .softstartSenseLimit, .useExtClock);

// ===== test/lss_board.sv
/*
  board model: sink pin levels for connected, unused and shorted strings,
  and the sync pin with its resistor and an optional external clock.
  assumes unusedM changes only while the sequencer is off.
*/
`timescale 1ns/1ns
module lss_board (
  input  wire logic             clk,
  input  wire lss_pkg::lss_ch_t unusedM,
  input  wire lss_pkg::lss_ch_t shortM,
  input  wire logic             syncRun,
  input  wire logic             fsetGnd,
  output      lss_pkg::lss_ch_t sinkAboveDetect,
  output      lss_pkg::lss_ch_t sinkBelowShort,
  output      lss_pkg::lss_ch_t sinkAboveLed,
  output      logic             freqSetSyncPin
);
  import lss_pkg::*;
  logic [7:0] phCnt = 8'h00;   // clocks into the half period
  logic       syncLvl = 1'b1;  // external clock level

  // pulldown holds an unused pin between detect and led levels
  assign sinkAboveDetect = ~shortM;
  assign sinkBelowShort  = shortM;
  assign sinkAboveLed    = ~shortM & ~unusedM;
  // fitted resistor keeps the pin high when no clock drives it
  assign freqSetSyncPin  = fsetGnd ? 1'b0 : (syncRun ? syncLvl : 1'b1);

  // 500 kHz push-pull clock, 1 us high then 1 us low
  always @(posedge clk) begin
    phCnt <= (syncRun && phCnt != 8'h63) ? phCnt + 8'h01 : 8'h00;
    if (!syncRun)
      syncLvl <= 1'b1;
    else if (phCnt == 8'h63)
      syncLvl <= ~syncLvl;
  end
endmodule

// ===== test/led_driver_startup_sequencer_tb.sv
/*
  self-checking bench for the led start-up sequencer.
  assumes lss_top, the board model and the checker are compiled first.
*/
`timescale 1ns/1ns
module led_driver_startup_sequencer_tb;
  import lss_pkg::*;
  logic        clk = 1'b0;
  logic        rstn, enable, supplyAboveRise, headroomOk, psel, penable, pwrite;
  logic        syncRun, fsetGnd, pready, pslverr, switchEn, softstartSinkGain;
  logic        softstartSenseLimit, useExtClock, freqSetSyncPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  lss_ch_t     sinkAboveDetect, sinkBelowShort, sinkAboveLed, sinkEn, unusedM, shortM;
  wire  [7:0]  outs = {switchEn, sinkEn, softstartSinkGain, softstartSenseLimit, useExtClock};
  int          failures = 0;
  int          checked = 0;

  lss_top i_dut (.clk, .rstn, .enable, .supplyAboveRise, .sinkAboveDetect, .sinkBelowShort,
    .sinkAboveLed, .headroomOk, .freqSetSyncPin, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .switchEn, .sinkEn, .softstartSinkGain, .softstartSenseLimit,
    .useExtClock);
  lss_board i_board (.clk, .unusedM, .shortM, .syncRun, .fsetGnd, .sinkAboveDetect,
    .sinkBelowShort, .sinkAboveLed, .freqSetSyncPin);

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic fail(input string what);
    failures++;
    $display("wrong value at %0t: %s", $time, what);
  endtask

  // masked compare of the sequencer outputs
  task automatic chkO(input logic [7:0] m, input logic [7:0] e);
    checked++;
    if ((outs & m) !== e)
      fail("sequencer outputs");
  endtask

  // one apb transfer; error flag is compared, and read data too on reads
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    checked++;
    if (pslverr !== err || (!wr && (prdata & m) !== e))
      fail("register access");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {rstn, enable, supplyAboveRise, headroomOk, psel, penable, pwrite, syncRun, fsetGnd} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    unusedM = 4'h8;
    shortM = 4'h0;
    cyc(20);
    rstn <= 1'b1;
    cyc(3);
    chkO(8'hFF, 8'h00);
    apb(1'b0, 12'h000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    enable <= 1'b1;
    cyc(2000);
    chkO(8'hFF, 8'h00);
    supplyAboveRise <= 1'b1;
    cyc(1530);
    chkO(8'hFF, 8'h00);
    cyc(70);
    chkO(8'hFF, 8'hBE);
    apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0008, 1'b0);
    headroomOk <= 1'b1;
    cyc(5);
    chkO(8'hFF, 8'hB8);
    enable <= 1'b0;
    cyc(5);
    chkO(8'hFF, 8'h00);
    headroomOk <= 1'b0;
    unusedM <= 4'h0;
    shortM <= 4'h1;
    enable <= 1'b1;
    cyc(3000);
    chkO(8'hFF, 8'h00);
    apb(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0007, 32'h0000_0003, 1'b0);
    shortM <= 4'h0;
    cyc(1600);
    chkO(8'hFF, 8'hFE);
    headroomOk <= 1'b1;
    fsetGnd <= 1'b1;
    cyc(450);
    chkO(8'hF8, 8'h00);
    cyc(300);
    headroomOk <= 1'b0;
    fsetGnd <= 1'b0;
    cyc(5);
    chkO(8'h7E, 8'h7E);
    apb(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0007, 32'h0000_0004, 1'b0);
    cyc(600);
    chkO(8'hFF, 8'hFE);
    syncRun <= 1'b1;
    cyc(150);
    chkO(8'h81, 8'h01);
    cyc(600);
    chkO(8'h81, 8'h81);
    syncRun <= 1'b0;
    cyc(450);
    chkO(8'h81, 8'h00);
    cyc(600);
    chkO(8'h81, 8'h80);
    apb(1'b1, 12'h000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b0);
    cyc(3);
    chkO(8'hFF, 8'h00);
    apb(1'b1, 12'h000, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0003, 1'b0);
    cyc(3);
    chkO(8'hFF, 8'hFE);
    supplyAboveRise <= 1'b0;
    cyc(3);
    chkO(8'hFF, 8'h00);
    end_sim;
  end

  // watchdog at about 1.75 times the expected run
  initial begin
    #200us;
    failures++;
    end_sim;
  end
endmodule
